// >>> common/aic_map.vh
// register map, field positions, reset values and timing figures of the analog input control
`ifndef AIC_MAP_VH
`define AIC_MAP_VH

// register indices; the bus byte address is four times the index
`define AIC_IDX_RES0 4'h0
`define AIC_IDX_RES1 4'h2
`define AIC_IDX_RES2 4'h4
`define AIC_IDX_RES3 4'h6
`define AIC_IDX_CTRL 4'h8
`define AIC_IDX_CHSEL 4'hA
`define AIC_IDX_STAT 4'hC
`define AIC_IDX_ACK 4'hE

// conversion_control_word fields
`define AIC_AC_BIT 15
`define AIC_INT_BIT 14
`define AIC_TA_MSB 2
`define AIC_TA_LSB 0
// channel_select_word field
`define AIC_CH_MSB 2
`define AIC_CH_LSB 0
// conversion_status_word fields
`define AIC_SC_BIT 0
`define AIC_EOC_BIT 0
`define AIC_PF_BIT 1

// reset values
`define AIC_AC_RST 1'b0
`define AIC_INT_RST 1'b0
`define AIC_TA_RST 3'h0
`define AIC_CH_RST 3'h1

// cycle-time codes
`define AIC_TA_5700US 3'h0
`define AIC_TA_2800US 3'h1
`define AIC_TA_1300US 3'h2
`define AIC_TA_600US 3'h3
`define AIC_TA_185US 3'h4

// cycle times in microseconds and the clock rate in MHz
`define AIC_T0_US 5700
`define AIC_T1_US 2800
`define AIC_T2_US 1300
`define AIC_T3_US 600
`define AIC_T4_US 185
`define AIC_CLK_MHZ 10

`endif

// >>> tb/aic_conv_model.sv
// behavioural external converter answering a start pulse after a fixed delay
`timescale 1ns/1ps
module aic_conv_model #(
    parameter int P_DELAY = 4
) (
    input wire i_sys_clk,
    input wire i_start,
    input wire [1:0] i_chan,
    input wire [7:0] i_salt,
    output wire o_done,
    output wire [15:0] o_data
);
    logic done_r = 1'b0;
    logic [15:0] data_r = 16'h0000;
    int cnt = 0;
    // data toggles while no result is valid, so a stale sample is caught
    always @(posedge i_sys_clk) begin
        if (i_start) begin
            done_r <= 1'b0;
            data_r <= ~data_r;
            cnt <= P_DELAY;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
            data_r <= (cnt == 1) ? {i_salt, 6'h00, i_chan} : ~data_r;
            done_r <= (cnt == 1);
        end
    end
    assign o_done = done_r;
    assign o_data = data_r;
endmodule // aic_conv_model

// >>> tb/aic_ctrl_props.sv
// checker for the control block's bus slave, request line and converter start
`timescale 1ns/1ps
module aic_ctrl_props (
    input wire i_sys_clk,
    input wire i_resetn,
    input wire i_ce,
    input wire [5:0] i_avs_address,
    input wire [3:0] i_avs_byteenable,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [31:0] o_avs_readdata,
    input wire o_avs_waitrequest,
    input wire o_module_interrupt_request,
    input wire o_adc_start,
    input wire [1:0] o_adc_chan
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    wire rd_acc = i_avs_read & ~o_avs_waitrequest;
    wire wr_acc = i_avs_write & ~o_avs_waitrequest;
    wire irq = o_module_interrupt_request;
    reg int_en_r;
    reg auto_r;
    reg [2:0] chsel_r;
    // shadow of what the host asked for; only accepted writes count
    always @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            int_en_r <= 1'b0;
            auto_r <= 1'b0;
            chsel_r <= 3'h1;
        end else if (wr_acc && i_avs_address == 6'h20 && i_avs_byteenable[1]) begin
            int_en_r <= i_avs_writedata[14];
            auto_r <= i_avs_writedata[15];
        end else if (wr_acc && i_avs_address == 6'h28 && i_avs_byteenable[0]) begin
            chsel_r <= i_avs_writedata[2:0];
        end
    end
    // a low clock enable freezes the slave, so the wait state only counts while it runs
    a_one_wait: assert property ((i_avs_read | i_avs_write) && o_avs_waitrequest && i_ce |=> !o_avs_waitrequest || !i_ce)
        else $error("no answer after one wait state");
    a_upper_zero: assert property (rd_acc |-> o_avs_readdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    a_unmapped_zero: assert property (rd_acc && i_avs_address[2:0] != 3'h0 |-> o_avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_ack_clears: assert property (wr_acc && i_avs_address == 6'h38 |=> !irq)
        else $error("request not cleared by acknowledge");
    a_irq_holds: assert property (irq && !(wr_acc && i_avs_address == 6'h38) |=> irq)
        else $error("request dropped without acknowledge");
    a_irq_gated: assert property (!int_en_r && !irq |=> !irq)
        else $error("request raised while disabled");
    a_irq_after_sweep: assert property ($rose(irq) |-> o_adc_chan == 2'h3)
        else $error("request raised before last channel");
    a_start_pulse: assert property (o_adc_start && i_ce |=> !o_adc_start)
        else $error("start longer than one cycle");
    a_chan_hold: assert property (!o_adc_start |=> o_adc_start || $stable(o_adc_chan))
        else $error("channel changed without start");
    a_single_go: assert property (wr_acc && i_avs_address == 6'h30 && i_avs_writedata[0] && !auto_r
        && chsel_r != 3'h0 && chsel_r < 3'h5 |-> ##[1:20] (o_adc_start && {1'b0, o_adc_chan} == chsel_r - 3'h1))
        else $error("single conversion not launched on selected channel");
    c_irq: cover property ($rose(irq));
    c_single: cover property (o_adc_start && !auto_r);
    c_unmapped: cover property (rd_acc && i_avs_address[2:0] != 3'h0);
endmodule // aic_ctrl_props

bind aic_ctrl aic_ctrl_props u_props (.i_sys_clk, .i_resetn, .i_ce, .i_avs_address, .i_avs_byteenable, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .o_module_interrupt_request, .o_adc_start, .o_adc_chan);

// >>> tb/tb.sv
// self-checking bench for the analog input control block
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [5:0] addr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic power_fail = 1'b0;
    logic ce = 1'b1;
    logic [3:0] be = 4'h3;
    logic [7:0] salt = 8'h00;
    logic [15:0] q;
    wire [31:0] rdata;
    wire waitreq, irq, adc_start, adc_done;
    wire [1:0] adc_chan;
    wire [15:0] adc_data;
    int n_errors = 0;
    int n_compared = 0;
    int cnt0 = 0;
    int gap = 0;
    int n0 = 0;

    // 10 MHz
    always #50 sys_clk = ~sys_clk;

    aic_ctrl #(.P_CYC_5700US(17'h190), .P_CYC_2800US(17'h12C), .P_CYC_1300US(17'h0FA), .P_CYC_600US(17'h0C8),
        .P_CYC_185US(17'h096)) dut (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_ce(ce), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(be), .i_avs_writedata(wdata),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .o_module_interrupt_request(irq),
        .o_adc_start(adc_start), .o_adc_chan(adc_chan), .i_adc_done(adc_done), .i_adc_data(adc_data),
        .i_ext_power_fail(power_fail));
    aic_conv_model u_conv (.i_sys_clk(sys_clk), .i_start(adc_start), .i_chan(adc_chan), .i_salt(salt),
        .o_done(adc_done), .o_data(adc_data));

    // cycles between channel 0 launches give the sweep period
    always @(posedge sys_clk) begin
        cnt0 <= cnt0 + 1;
        if (adc_start === 1'b1 && adc_chan === 2'h0) begin
            gap <= cnt0;
            cnt0 <= 1;
            n0 <= n0 + 1;
        end
    end

    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic timeout(input string what);
        n_errors++;
        $display("mismatch %s expected finish seen timeout", what);
        test_done();
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one bus access; waitrequest and read data are taken at the rising edge that samples waitrequest low
    // writes leave q cleared so a poll loop never acts on a stale read
    task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
        int k;
        k = 0;
        @(posedge sys_clk);
        addr <= a;
        wdata <= {16'h0000, d};
        rd <= ~w;
        wr <= w;
        do begin
            @(posedge sys_clk);
            k++;
        end while (waitreq !== 1'b0 && k < 50);
        q = w ? 16'h0000 : rdata[15:0];
        rd <= 1'b0;
        wr <= 1'b0;
        if (k >= 50) timeout("waitrequest");
    endtask

    task automatic rd_chk(input string name, input logic [5:0] a, input logic [15:0] exp);
        bus(1'b0, a, 16'h0000);
        check(name, q, exp);
    endtask

    // bounded wait for a number of sweeps, or for the request line
    task automatic wait_ev(input bit on_irq, input int n);
        int k;
        k = n0 + n;
        repeat (3000) if (on_irq ? irq !== 1'b1 : n0 < k) @(posedge sys_clk);
        if (on_irq ? irq !== 1'b1 : n0 < k) timeout("event");
        @(negedge sys_clk);
    endtask

    function automatic logic [15:0] period(input int t);
        case (t)
            1: return 16'h012C;
            2: return 16'h00FA;
            3: return 16'h00C8;
            4: return 16'h0096;
            default: return 16'h0190;
        endcase
    endfunction

    initial begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        // reset values and unmapped places
        rd_chk("control", 6'h20, 16'h0000);
        rd_chk("channel select", 6'h28, 16'h0001);
        rd_chk("status", 6'h30, 16'h0000);
        for (int c = 0; c < 4; c++) rd_chk("result", 6'(c * 8), 16'h0000);
        rd_chk("unmapped", 6'h3C, 16'h0000);
        rd_chk("misaligned", 6'h22, 16'h0000);
        $display("reset test finished");
        // select, start, poll, read on every channel
        for (int c = 0; c < 4; c++) begin
            salt <= 8'h10 + 8'(c);
            bus(1'b1, 6'h28, 16'(c + 1));
            bus(1'b1, 6'h30, 16'h0001);
            repeat (40) if (q[0] !== 1'b1) bus(1'b0, 6'h30, 16'h0000);
            check("status", q, 16'h0001);
            rd_chk("result", 6'(c * 8), {8'h10 + 8'(c), 6'h00, 2'(c)});
        end
        rd_chk("channel select", 6'h28, 16'h0004);
        // the select field sits in lane 0, so a lane 1 only write leaves it alone
        be <= 4'h2;
        bus(1'b1, 6'h28, 16'h0002);
        be <= 4'h3;
        rd_chk("lane select", 6'h28, 16'h0004);
        // an invalid channel code must not start anything
        power_fail <= 1'b1;
        bus(1'b1, 6'h28, 16'h0000);
        bus(1'b1, 6'h30, 16'h0001);
        rd_chk("status", 6'h30, 16'h0002);
        power_fail <= 1'b0;
        $display("single conversion test finished");
        // sweeps at every cycle-time code, one past the listed codes included
        for (int t = 0; t < 6; t++) begin
            bus(1'b1, 6'h20, 16'hC000 | 16'(t));
            wait_ev(1'b0, 3);
            check("cycle time", gap[15:0], period(t));
            // a clock-enable pause of 20 cycles stretches one period by exactly that much
            if (t == 4) begin
                @(posedge sys_clk);
                ce <= 1'b0;
                repeat (20) @(posedge sys_clk);
                ce <= 1'b1;
                wait_ev(1'b0, 1);
                check("frozen cycle", gap[15:0], period(t) + 16'h0014);
            end
        end
        salt <= 8'h5A;
        wait_ev(1'b0, 1);
        bus(1'b1, 6'h38, 16'hFFFF);
        @(negedge sys_clk);
        check("request", {15'h0000, irq}, 16'h0000);
        wait_ev(1'b1, 0);
        for (int c = 0; c < 4; c++) rd_chk("result", 6'(c * 8), {8'h5A, 6'h00, 2'(c)});
        bus(1'b1, 6'h38, 16'h0000);
        @(negedge sys_clk);
        check("request", {15'h0000, irq}, 16'h0000);
        bus(1'b1, 6'h20, 16'h8004);
        rd_chk("control", 6'h20, 16'h8004);
        wait_ev(1'b0, 2);
        check("request", {15'h0000, irq}, 16'h0000);
        bus(1'b1, 6'h20, 16'h0000);
        $display("automatic conversion test finished");
        test_done();
    end

    // overall limit so a hang still reaches the verdict
    initial begin
        #5000000;
        timeout("run");
    end
endmodule // tb

// >>> verilog/aic_conv_if.v
// handshake with the external converter: start pulse out, synchronised done and result in
`timescale 1ns/1ps
module aic_conv_if (
    input wire i_sys_clk,
    input wire i_resetn,
    input wire i_ce,
    input wire i_req,
    input wire [1:0] i_chan,
    output wire o_busy,
    output reg o_done,
    output reg [15:0] o_data,
    output reg o_adc_start,
    output reg [1:0] o_adc_chan,
    input wire i_adc_done,
    input wire [15:0] i_adc_data
);

reg done_m_r;
reg done_s_r;
reg done_d_r;
reg [15:0] data_m_r;
reg [15:0] data_s_r;
reg busy_r;

assign o_busy = busy_r;

// two-stage synchronisers; only the second stage and beyond are looked at
always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
        done_m_r <= 1'b0;
        done_s_r <= 1'b0;
        done_d_r <= 1'b0;
        data_m_r <= 16'h0000;
        data_s_r <= 16'h0000;
    end else if (i_ce) begin
        done_m_r <= i_adc_done;
        done_s_r <= done_m_r;
        done_d_r <= done_s_r;
        data_m_r <= i_adc_data;
        data_s_r <= data_m_r;
    end
end

// one conversion at a time; result caught on the rising edge of done
// limitation: the converter must hold data stable from done rising until its next start
always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
        busy_r <= 1'b0;
        o_done <= 1'b0;
        o_data <= 16'h0000;
        o_adc_start <= 1'b0;
        o_adc_chan <= 2'h0;
    end else if (i_ce) begin
        o_done <= 1'b0;
        o_adc_start <= 1'b0;
        if (!busy_r && i_req) begin
            busy_r <= 1'b1;
            o_adc_start <= 1'b1;
            o_adc_chan <= i_chan;
        end else if (busy_r && done_s_r && !done_d_r && !o_adc_start) begin
            busy_r <= 1'b0;
            o_done <= 1'b1;
            o_data <= data_s_r;
        end
    end
end

endmodule // aic_conv_if

// >>> verilog/aic_ctrl.v
// analog input conversion control: register slave, cycle pacing and conversion sequencing
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "aic_map.vh"

// What this block does
// RULE1: cycle-time field paces automatic conversion cycles
// RULE2: auto-convert bit repeats sweeps over all channels
// RULE3: interrupt enable raises request per completed sweep
// RULE4: channel select at 0A, code 001 is channel0
// RULE5: writing start bit begins one conversion
// RULE6: done bit reports on-demand conversion finished
// RULE7: channel results readable at offsets 00 to 06
// RULE8: any write to 0E clears the request
// RULE9: host selects, starts, polls done, then reads
// RULE10: host enables auto, waits, reads, then acknowledges
// RULE11: cycle event goes out on one request line
// RULE12: reset clears control, selects channel0, clears request
module aic_ctrl #(
    parameter [16:0] P_CYC_5700US = `AIC_T0_US * `AIC_CLK_MHZ,
    parameter [16:0] P_CYC_2800US = `AIC_T1_US * `AIC_CLK_MHZ,
    parameter [16:0] P_CYC_1300US = `AIC_T2_US * `AIC_CLK_MHZ,
    parameter [16:0] P_CYC_600US = `AIC_T3_US * `AIC_CLK_MHZ,
    parameter [16:0] P_CYC_185US = `AIC_T4_US * `AIC_CLK_MHZ
) (
    input wire i_sys_clk,
    input wire i_resetn,
    input wire i_ce,
    // avalon-mm slave, byte addressed
    input wire [5:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [3:0] i_avs_byteenable,
    input wire [31:0] i_avs_writedata,
    output reg [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    // interrupt request line
    output reg o_module_interrupt_request,
    // external converter
    output wire o_adc_start,
    output wire [1:0] o_adc_chan,
    input wire i_adc_done,
    input wire [15:0] i_adc_data,
    input wire i_ext_power_fail
);

// sequencer states
localparam [1:0] ST_IDLE = 2'b00;
localparam [1:0] ST_SWEEP = 2'b01;
localparam [1:0] ST_SINGLE = 2'b10;

// period of one automatic cycle in clock cycles
function [16:0] period_of;
    input [2:0] ta;
    begin
        case (ta)
            `AIC_TA_5700US: period_of = P_CYC_5700US;
            `AIC_TA_2800US: period_of = P_CYC_2800US;
            `AIC_TA_1300US: period_of = P_CYC_1300US;
            `AIC_TA_600US: period_of = P_CYC_600US;
            `AIC_TA_185US: period_of = P_CYC_185US;
            default: period_of = P_CYC_5700US;
        endcase
    end
endfunction

// individual channel encoding: 001..100 name channels 0..3, others are invalid
function code_ok;
    input [2:0] code;
    begin
        code_ok = (code >= 3'h1) && (code <= 3'h4);
    end
endfunction

// register state
reg auto_convert_enable_r;
reg cycle_irq_enable_r;
reg [2:0] cycle_time_select_r;
reg [2:0] chan_code_r;
reg eoc_r;
reg [15:0] result_r [0:3];

// bus handshake and decode
reg ack_r;
wire bus_req;
wire bus_take;
wire [3:0] reg_idx;
wire word_ok;
wire wr_low;

// sequencer and timing
reg [1:0] state_r;
reg [1:0] sweep_ch_r;
reg [1:0] single_ch_r;
reg sweep_pend_r;
reg single_pend_r;
reg conv_req_r;
reg [1:0] conv_ch_r;
reg [16:0] cyc_cnt_r;
reg cycle_done_r;
reg pf_m_r;
reg pf_s_r;

wire conv_busy;
wire conv_done;
wire [15:0] conv_data;
wire cyc_tick;
wire start_wr;
wire ack_wr;

// one wait state per access: the answer comes at the second edge of the request
assign bus_req = i_avs_read | i_avs_write;
assign bus_take = bus_req & ack_r & i_ce;
assign o_avs_waitrequest = bus_req & ~(ack_r & i_ce);
assign reg_idx = i_avs_address[5:2];
assign word_ok = (i_avs_address[1:0] == 2'b00);
assign wr_low = bus_take & i_avs_write & word_ok & i_avs_byteenable[0];

// strobes from the bus
assign start_wr = wr_low & (reg_idx == `AIC_IDX_STAT) & i_avs_writedata[`AIC_SC_BIT]; // [RULE5]
assign ack_wr = bus_take & i_avs_write & word_ok & (reg_idx == `AIC_IDX_ACK); // [RULE8]

// ack toggles so that a held request completes once and then may repeat
always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
        ack_r <= 1'b0;
    end else if (i_ce) begin
        ack_r <= bus_req & ~ack_r;
    end
end

// read mux, loaded at the edge before waitrequest drops so data is registered
always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
        o_avs_readdata <= 32'h0000_0000;
    end else if (i_ce && i_avs_read && !ack_r) begin
        o_avs_readdata <= 32'h0000_0000;
        if (word_ok) begin
            case (reg_idx)
                `AIC_IDX_RES0: o_avs_readdata[15:0] <= result_r[0]; // [RULE7]
                `AIC_IDX_RES1: o_avs_readdata[15:0] <= result_r[1]; // [RULE7]
                `AIC_IDX_RES2: o_avs_readdata[15:0] <= result_r[2]; // [RULE7]
                `AIC_IDX_RES3: o_avs_readdata[15:0] <= result_r[3]; // [RULE7]
                `AIC_IDX_CTRL: begin
                    o_avs_readdata[`AIC_AC_BIT] <= auto_convert_enable_r;
                    o_avs_readdata[`AIC_INT_BIT] <= cycle_irq_enable_r;
                    o_avs_readdata[`AIC_TA_MSB:`AIC_TA_LSB] <= cycle_time_select_r;
                end
                `AIC_IDX_CHSEL: o_avs_readdata[`AIC_CH_MSB:`AIC_CH_LSB] <= chan_code_r;
                `AIC_IDX_STAT: begin
                    o_avs_readdata[`AIC_EOC_BIT] <= eoc_r; // [RULE6]
                    o_avs_readdata[`AIC_PF_BIT] <= pf_s_r;
                end
                default: o_avs_readdata <= 32'h0000_0000;
            endcase
        end
    end
end

// control words; only the low byte lane carries live bits, except the auto and interrupt enable bits in lane 1
always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
        auto_convert_enable_r <= `AIC_AC_RST; // [RULE12]
        cycle_irq_enable_r <= `AIC_INT_RST; // [RULE12]
        cycle_time_select_r <= `AIC_TA_RST; // [RULE12]
        chan_code_r <= `AIC_CH_RST; // [RULE12]
    end else if (i_ce && bus_take && i_avs_write && word_ok) begin
        if (reg_idx == `AIC_IDX_CTRL) begin
            if (i_avs_byteenable[1]) begin
                auto_convert_enable_r <= i_avs_writedata[`AIC_AC_BIT]; // [RULE2]
                cycle_irq_enable_r <= i_avs_writedata[`AIC_INT_BIT]; // [RULE3]
            end
            if (i_avs_byteenable[0]) begin
                cycle_time_select_r <= i_avs_writedata[`AIC_TA_MSB:`AIC_TA_LSB]; // [RULE1]
            end
        end
        if (reg_idx == `AIC_IDX_CHSEL && i_avs_byteenable[0]) begin
            chan_code_r <= i_avs_writedata[`AIC_CH_MSB:`AIC_CH_LSB]; // [RULE4]
        end
    end
end

// power-fail pin comes from outside the clock domain
always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
        pf_m_r <= 1'b0;
        pf_s_r <= 1'b0;
    end else if (i_ce) begin
        pf_m_r <= i_ext_power_fail;
        pf_s_r <= pf_m_r;
    end
end

// cycle timer: first sweep begins at once on enable, then one per period
// a shorter code written mid-period takes effect at once because of the >= compare
assign cyc_tick = auto_convert_enable_r & (cyc_cnt_r == 17'h0_0000); // [RULE2]
always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
        cyc_cnt_r <= 17'h0_0000;
    end else if (i_ce) begin
        if (!auto_convert_enable_r) begin
            cyc_cnt_r <= 17'h0_0000;
        end else if (cyc_cnt_r >= period_of(cycle_time_select_r) - 17'h0_0001) begin
            cyc_cnt_r <= 17'h0_0000; // [RULE1]
        end else begin
            cyc_cnt_r <= cyc_cnt_r + 17'h0_0001;
        end
    end
end

// sequencer: sweeps over all channels take priority over single conversions
// a tick that lands while a sweep still runs is kept pending, never stacked
always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
        state_r <= ST_IDLE;
        sweep_ch_r <= 2'h0;
        single_ch_r <= 2'h0;
        sweep_pend_r <= 1'b0;
        single_pend_r <= 1'b0;
        conv_req_r <= 1'b0;
        conv_ch_r <= 2'h0;
        cycle_done_r <= 1'b0;
    end else if (i_ce) begin
        conv_req_r <= 1'b0;
        cycle_done_r <= 1'b0;
        if (cyc_tick) begin
            sweep_pend_r <= 1'b1;
        end
        if (!auto_convert_enable_r) begin
            sweep_pend_r <= 1'b0;
        end
        // invalid channel codes leave the start unanswered
        if (start_wr && code_ok(chan_code_r)) begin
            single_pend_r <= 1'b1; // [RULE5]
            single_ch_r <= chan_code_r[1:0] - 2'h1; // [RULE4]
        end
        case (state_r)
            ST_IDLE: begin
                if (sweep_pend_r && auto_convert_enable_r && !conv_busy) begin
                    sweep_pend_r <= cyc_tick;
                    sweep_ch_r <= 2'h0;
                    conv_ch_r <= 2'h0;
                    conv_req_r <= 1'b1; // [RULE2]
                    state_r <= ST_SWEEP;
                end else if (single_pend_r && !conv_busy && !start_wr) begin
                    single_pend_r <= 1'b0;
                    conv_ch_r <= single_ch_r;
                    conv_req_r <= 1'b1; // [RULE5]
                    state_r <= ST_SINGLE;
                end
            end
            ST_SWEEP: begin
                if (conv_done) begin
                    if (sweep_ch_r == 2'h3) begin
                        cycle_done_r <= 1'b1; // [RULE3]
                        state_r <= ST_IDLE;
                    end else begin
                        sweep_ch_r <= sweep_ch_r + 2'h1;
                        conv_ch_r <= sweep_ch_r + 2'h1;
                        conv_req_r <= 1'b1;
                    end
                end
            end
            ST_SINGLE: begin
                if (conv_done) begin
                    state_r <= ST_IDLE;
                end
            end
            default: state_r <= ST_IDLE;
        endcase
    end
end

// result words: written by whichever conversion just finished
always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
        result_r[0] <= 16'h0000;
        result_r[1] <= 16'h0000;
        result_r[2] <= 16'h0000;
        result_r[3] <= 16'h0000;
    end else if (i_ce && conv_done) begin
        result_r[conv_ch_r] <= conv_data; // [RULE7]
    end
end

// done flag: cleared by a new start, set by a finished single conversion; set wins
always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
        eoc_r <= 1'b0;
    end else if (i_ce) begin
        if (conv_done && state_r == ST_SINGLE) begin
            eoc_r <= 1'b1; // [RULE6]
        end else if (start_wr) begin
            eoc_r <= 1'b0;
        end
    end
end

// request line: held until acknowledged; a cycle ending with the ack keeps it set
always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
        o_module_interrupt_request <= 1'b0;
    end else if (i_ce) begin
        if (cycle_done_r && cycle_irq_enable_r) begin
            o_module_interrupt_request <= 1'b1; // [RULE3] [RULE11]
        end else if (ack_wr) begin
            o_module_interrupt_request <= 1'b0; // [RULE8] [RULE12]
        end
    end
end

// converter handshake
aic_conv_if u_conv (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_req(conv_req_r),
    .i_chan(conv_ch_r),
    .o_busy(conv_busy),
    .o_done(conv_done),
    .o_data(conv_data),
    .o_adc_start(o_adc_start),
    .o_adc_chan(o_adc_chan),
    .i_adc_done(i_adc_done),
    .i_adc_data(i_adc_data)
);

endmodule // aic_ctrl
